// File: rtl/ups_pkg.sv
// Purpose: Shared constants for the USB port protection sequencer.
// Assumes: 50 MHz time-base clock, APB register access.
// Notes: Times are kept in their own units; cycle counts derive from them.
`default_nettype none
package ups_pkg;
  // ---------------------------------------------------------------
  // Clock and times
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1_000;
  localparam int unsigned T_DSW_ON_US = 800;
  localparam int unsigned T_DOVP_PG_US = 100;
  localparam int unsigned T_DOVP_SW_US = 5;
  localparam int unsigned T_RST_SHORT_MS = 400;
  localparam int unsigned T_RST_LONG_S = 2;
  localparam int unsigned T_SAFE0V_MS = 675;
  localparam int unsigned DOVP_SW_CYC = T_DOVP_SW_US * CLK_PER_US;
  localparam int unsigned DSW_ON_CYC = T_DSW_ON_US * CLK_PER_US;
  localparam int unsigned DOVP_PG_CYC = T_DOVP_PG_US * CLK_PER_US;
  localparam int unsigned RST_SHORT_CYC = T_RST_SHORT_MS * CLK_PER_MS;
  localparam int unsigned RST_LONG_CYC = T_RST_LONG_S * CLK_HZ;
  localparam int unsigned SAFE0V_CYC = T_SAFE0V_MS * CLK_PER_MS;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_MODE_LSB = 1;
  localparam logic CTRL_EN_RST = 1'b0;

  typedef enum logic [1:0] {
    MODE_SDP = 2'b00,
    MODE_CDP = 2'b01,
    MODE_DCP = 2'b10
  } ups_mode_e;
  localparam logic [1:0] MODE_RST = 2'h2;

  typedef enum logic [2:0] {
    P_OFF = 3'b000,
    P_SS = 3'b001,
    P_RUN = 3'b010,
    P_RST = 3'b011,
    P_OTP = 3'b100
  } ups_pwr_e;

  typedef enum logic [1:0] {
    C_UNATT = 2'b00,
    C_ATT = 2'b01,
    C_DET = 2'b10,
    C_OVP = 2'b11
  } ups_cc_e;

  // Synchronised input vector positions
  localparam int unsigned NIN = 14;
  localparam int unsigned I_OTP = 0;
  localparam int unsigned I_DP = 1;
  localparam int unsigned I_DN = 2;
  localparam int unsigned I_CC1OV = 3;
  localparam int unsigned I_CC2OV = 4;
  localparam int unsigned I_CC1RD = 5;
  localparam int unsigned I_CC2RD = 6;
  localparam int unsigned I_SAFE0V = 7;
  localparam int unsigned I_FBLOW = 8;
  localparam int unsigned I_OVP = 9;
  localparam int unsigned I_UVP = 10;
  localparam int unsigned I_POR = 11;
  localparam int unsigned I_SSDONE = 12;
  localparam int unsigned I_TMO = 13;
endpackage : ups_pkg
`default_nettype wire

// File: rtl/ups_sequencer.sv
// Purpose: Port protection and power sequencing for a Type-C charging port.
// Assumes: Comparator flags are asynchronous; APB master follows APB4.
// Notes: Long counts are top-level parameters so simulation can shorten them.
//
// Function
// - Over-temperature stops all converter switching
// - Over-temperature release restarts through full soft-start
// - Charging mode change starts VBUS reset
// - Reset: converter off, discharge VBUS, re-enable
// - Timeout during reset repeats the reset
// - Reset 400ms from DCP down, else 2s
// - Protection release or low feedback starts reset
// - Data switch closed in CDP or SDP
// - Data switch closes 800us after supply POR
// - Data switch opens when supply falls below POR
// - Data line overvoltage: power-good low, switch open
// - Recovery after clear: same delays released
// - Power-good rise after data overvoltage: 400ms reset
// - Source only; watch CC for Rd, drive gate
// - Rd attach turns blocking gate on within 150ms
// - Detach: open CC, await vSafe0V, pull-up again
// - Force CC pull-up after 675ms wait
// - CC overvoltage: power-good low, gate off
// - CC overvoltage discharges VBUS within 35ms
// - CC overvoltage clear: power-good high, await attach
// - Any protection holds power-good low
`default_nettype none

// -----------------------------------------------------------------
// Asymmetric persistence filter
// -----------------------------------------------------------------
module ups_delay #(
  parameter int unsigned RISE = 1,
  parameter int unsigned FALL = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Level in and filtered level out
  input wire logic d,
  output logic q
);
  logic [31:0] cnt_reg;
  wire [31:0] lim = d ? 32'(RISE) : 32'(FALL);
  wire hit = (cnt_reg >= lim - 32'h1);

  // Count restarts whenever the input returns to the output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 32'h0;
      q <= 1'b0;
    end else if (d == q) begin
      cnt_reg <= 32'h0;
    end else if (hit) begin
      cnt_reg <= 32'h0;
      q <= d;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
    end
  end
endmodule : ups_delay

// -----------------------------------------------------------------
// Top
// -----------------------------------------------------------------
module ups_sequencer
  import ups_pkg::*;
#(
  parameter int unsigned DSW_ON_CYCLES = DSW_ON_CYC,
  parameter int unsigned DOVP_PG_CYCLES = DOVP_PG_CYC,
  parameter int unsigned RST_SHORT_CYCLES = RST_SHORT_CYC,
  parameter int unsigned RST_LONG_CYCLES = RST_LONG_CYC,
  parameter int unsigned SAFE0V_CYCLES = SAFE0V_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Comparator flags
  input wire logic over_temp,
  input wire logic host_data_pos_ovp,
  input wire logic host_data_neg_ovp,
  input wire logic cc1_ovp,
  input wire logic cc2_ovp,
  input wire logic cc1_rd_seen,
  input wire logic cc2_rd_seen,
  input wire logic vbus_safe0v,
  input wire logic feedback_node_low,
  input wire logic overvoltage_trip,
  input wire logic undervoltage_trip,
  input wire logic vcc_por_ok,
  input wire logic soft_start_done,
  input wire logic reset_timeout,
  // Controls
  output logic converter_enable,
  output logic soft_start_pulldown,
  output logic vbus_discharge,
  output logic data_switch_on,
  output logic power_good_out,
  output logic blocking_gate_on,
  output logic cc1_pullup_on,
  output logic cc2_pullup_on
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  wire [NIN-1:0] raw = {reset_timeout, soft_start_done, vcc_por_ok, undervoltage_trip,
                        overvoltage_trip, feedback_node_low, vbus_safe0v, cc2_rd_seen,
                        cc1_rd_seen, cc2_ovp, cc1_ovp, host_data_neg_ovp,
                        host_data_pos_ovp, over_temp};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= raw;
      s2_reg <= s1_reg;
    end
  end

  wire otp_s = s2_reg[I_OTP];
  wire dovp_s = s2_reg[I_DP] | s2_reg[I_DN];
  wire ccovp_s = s2_reg[I_CC1OV] | s2_reg[I_CC2OV];
  wire rd1_s = s2_reg[I_CC1RD];
  wire rd2_s = s2_reg[I_CC2RD];
  wire safe0v_s = s2_reg[I_SAFE0V];
  wire fblow_s = s2_reg[I_FBLOW];
  wire ovuv_s = s2_reg[I_OVP] | s2_reg[I_UVP];
  wire por_s = s2_reg[I_POR];
  wire ssdone_s = s2_reg[I_SSDONE];
  wire tmo_s = s2_reg[I_TMO];

  // ---------------------------------------------------------------
  // APB registers
  // ---------------------------------------------------------------
  logic en_reg;
  logic [1:0] mode_reg;
  logic [1:0] mode_prev_reg;
  ups_pwr_e pst_reg;
  ups_cc_e cst_reg;
  logic act_cc2_reg;

  wire sel_ctrl = (paddr == CTRL_OFS);
  wire sel_stat = (paddr == STAT_OFS);
  wire acc = psel & penable;
  wire wr_ctrl = acc & pwrite & sel_ctrl & pstrb[0];
  wire [1:0] wmode = pwdata[CTRL_MODE_LSB +: 2];
  // Code 3 is not a mode; such a write keeps the previous one
  wire wmode_ok = (wmode != 2'h3);

  assign pready = 1'b1;
  assign pslverr = acc & ~(sel_ctrl | (sel_stat & ~pwrite));
  assign prdata = sel_ctrl ? {29'h0, mode_reg, en_reg} :
                  sel_stat ? {20'h0, act_cc2_reg, cst_reg, pst_reg, cc2_pullup_on,
                              cc1_pullup_on, blocking_gate_on, data_switch_on,
                              power_good_out, converter_enable} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg <= CTRL_EN_RST;
      mode_reg <= MODE_RST;
      mode_prev_reg <= MODE_RST;
    end else begin
      mode_prev_reg <= mode_reg;
      if (wr_ctrl) begin
        en_reg <= pwdata[CTRL_EN_BIT];
        if (wmode_ok) begin
          mode_reg <= wmode;
        end
      end
    end
  end

  wire mode_chg = (mode_reg != mode_prev_reg);
  wire mode_dcp_down = (mode_prev_reg == MODE_DCP) & (mode_reg != MODE_DCP);

  // ---------------------------------------------------------------
  // Delay filters
  // ---------------------------------------------------------------
  logic por_dly;
  logic dovp_sw;
  logic dovp_pg;

  ups_delay #(.RISE(DSW_ON_CYCLES), .FALL(1)) u_por (
    .pclk(pclk), .presetn(presetn), .d(por_s), .q(por_dly));
  ups_delay #(.RISE(DOVP_SW_CYC), .FALL(DOVP_SW_CYC)) u_dsw (
    .pclk(pclk), .presetn(presetn), .d(dovp_s), .q(dovp_sw));
  ups_delay #(.RISE(DOVP_PG_CYCLES), .FALL(DOVP_PG_CYCLES)) u_dpg (
    .pclk(pclk), .presetn(presetn), .d(dovp_s), .q(dovp_pg));

  // ---------------------------------------------------------------
  // Power sequencing
  // ---------------------------------------------------------------
  logic [31:0] rst_cnt_reg;
  logic [31:0] rst_len_reg;
  logic ovuv_prev_reg;
  logic dovp_seen_reg;
  logic pg_reg;

  wire pg_next = (pst_reg == P_RUN) & ~dovp_pg & ~ccovp_s & ~ovuv_s & ~fblow_s & ~otp_s;
  wire pg_rise_dovp = pg_next & ~pg_reg & dovp_seen_reg;
  wire ovuv_rel = ovuv_prev_reg & ~ovuv_s;
  wire run_like = (pst_reg == P_SS) | (pst_reg == P_RUN) | (pst_reg == P_RST);
  wire rst_req = run_like & (mode_chg | ovuv_rel | pg_rise_dovp |
                 (fblow_s & (pst_reg == P_RUN)));
  wire rst_short = pg_rise_dovp | (mode_chg & mode_dcp_down);
  wire rst_done = (rst_cnt_reg >= rst_len_reg - 32'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pst_reg <= P_OFF;
      rst_cnt_reg <= 32'h0;
      rst_len_reg <= 32'(RST_LONG_CYCLES);
      ovuv_prev_reg <= 1'b0;
      dovp_seen_reg <= 1'b0;
      pg_reg <= 1'b0;
    end else begin
      ovuv_prev_reg <= ovuv_s;
      pg_reg <= pg_next;
      if (dovp_pg) begin
        dovp_seen_reg <= 1'b1;
      end else if (pg_rise_dovp) begin
        dovp_seen_reg <= 1'b0;
      end
      if (!en_reg) begin
        pst_reg <= P_OFF;
      end else if (otp_s) begin
        pst_reg <= P_OTP;
      end else if (rst_req) begin
        pst_reg <= P_RST;
        rst_cnt_reg <= 32'h0;
        rst_len_reg <= rst_short ? 32'(RST_SHORT_CYCLES) : 32'(RST_LONG_CYCLES);
      end else begin
        unique case (pst_reg)
          P_OFF: begin
            if (por_s) begin
              pst_reg <= P_SS;
            end
          end
          P_SS: begin
            if (ssdone_s) begin
              pst_reg <= P_RUN;
            end
          end
          P_RUN: begin
          end
          P_RST: begin
            if (tmo_s) begin
              rst_cnt_reg <= 32'h0;
            end else if (rst_done) begin
              pst_reg <= P_SS;
            end else begin
              rst_cnt_reg <= rst_cnt_reg + 32'h1;
            end
          end
          P_OTP: begin
            // Release goes through a full reset, then soft-start
            pst_reg <= P_RST;
            rst_cnt_reg <= 32'h0;
            rst_len_reg <= 32'(RST_LONG_CYCLES);
          end
          default: pst_reg <= P_OFF;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Type-C source attach and detach
  // ---------------------------------------------------------------
  logic [31:0] det_cnt_reg;
  wire rd_act = act_cc2_reg ? rd2_s : rd1_s;
  wire det_timeout = (det_cnt_reg >= 32'(SAFE0V_CYCLES) - 32'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_reg <= C_UNATT;
      act_cc2_reg <= 1'b0;
      det_cnt_reg <= 32'h0;
    end else if (ccovp_s) begin
      cst_reg <= C_OVP;
    end else begin
      unique case (cst_reg)
        C_UNATT: begin
          if (rd1_s | rd2_s) begin
            cst_reg <= C_ATT;
            act_cc2_reg <= rd2_s & ~rd1_s;
          end
        end
        C_ATT: begin
          if (!rd_act) begin
            cst_reg <= C_DET;
            det_cnt_reg <= 32'h0;
          end
        end
        C_DET: begin
          if (safe0v_s || det_timeout) begin
            cst_reg <= C_UNATT;
          end else begin
            det_cnt_reg <= det_cnt_reg + 32'h1;
          end
        end
        C_OVP: cst_reg <= C_UNATT;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  wire conv_next = ((pst_reg == P_SS) | (pst_reg == P_RUN)) & ~otp_s;
  wire dsw_next = por_dly & (mode_reg != MODE_DCP) & ~dovp_sw;
  wire dis_next = (pst_reg == P_RST) | (cst_reg == C_DET) | (cst_reg == C_OVP);
  wire gate_next = (cst_reg == C_ATT) & ~ccovp_s;
  wire det_open = (cst_reg == C_DET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_enable <= 1'b0;
      soft_start_pulldown <= 1'b0;
      vbus_discharge <= 1'b0;
      data_switch_on <= 1'b0;
      power_good_out <= 1'b0;
      blocking_gate_on <= 1'b0;
      cc1_pullup_on <= 1'b1;
      cc2_pullup_on <= 1'b1;
    end else begin
      converter_enable <= conv_next;
      soft_start_pulldown <= (pst_reg == P_RST);
      vbus_discharge <= dis_next;
      data_switch_on <= dsw_next;
      power_good_out <= pg_next;
      blocking_gate_on <= gate_next;
      cc1_pullup_on <= ~(det_open & ~act_cc2_reg);
      cc2_pullup_on <= ~(det_open & act_cc2_reg);
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  sequence s_otp_gone;
    (pst_reg == P_OTP) ##1 (pst_reg == P_RST);
  endsequence

  property p_otp_off;
    @(posedge pclk) disable iff (!presetn) otp_s |=> !converter_enable;
  endproperty
  a_otp_off: assert property (p_otp_off) else $error("switching during over-temperature");

  property p_otp_soft;
    @(posedge pclk) disable iff (!presetn)
      s_otp_gone |-> ##[1:2] (soft_start_pulldown && !converter_enable);
  endproperty
  a_otp_soft: assert property (p_otp_soft) else $error("no reset after over-temp");

  property p_mode_rst;
    @(posedge pclk) disable iff (!presetn)
      (mode_chg && en_reg && !otp_s && run_like) |=> ##1 soft_start_pulldown;
  endproperty
  a_mode_rst: assert property (p_mode_rst) else $error("mode change without reset");

  property p_rst_off;
    @(posedge pclk) disable iff (!presetn)
      (pst_reg == P_RST) |=> (!converter_enable && vbus_discharge);
  endproperty
  a_rst_off: assert property (p_rst_off) else $error("converter on during reset");

  property p_tmo_rep;
    @(posedge pclk) disable iff (!presetn)
      (pst_reg == P_RST && tmo_s && en_reg && !otp_s && !rst_req) |=> (rst_cnt_reg == 32'h0);
  endproperty
  a_tmo_rep: assert property (p_tmo_rep) else $error("timeout did not restart reset");

  property p_rst_len;
    @(posedge pclk) disable iff (!presetn)
      (rst_req && en_reg && !otp_s && mode_chg && mode_dcp_down)
        |=> (rst_len_reg == 32'(RST_SHORT_CYCLES));
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("wrong reset length");

  property p_dcp_open;
    @(posedge pclk) disable iff (!presetn) (mode_reg == MODE_DCP) |=> !data_switch_on;
  endproperty
  a_dcp_open: assert property (p_dcp_open) else $error("data switch closed in DCP");

  property p_por_open;
    @(posedge pclk) disable iff (!presetn) !por_s |=> ##1 !data_switch_on;
  endproperty
  a_por_open: assert property (p_por_open) else $error("data switch kept past POR");

  property p_cc_ovp;
    @(posedge pclk) disable iff (!presetn)
      ccovp_s |=> (!blocking_gate_on && !power_good_out) ##1 vbus_discharge;
  endproperty
  a_cc_ovp: assert property (p_cc_ovp) else $error("CC overvoltage response missing");

  property p_safe0v_cap;
    @(posedge pclk) disable iff (!presetn)
      (cst_reg == C_DET) |-> (det_cnt_reg < 32'(SAFE0V_CYCLES));
  endproperty
  a_safe0v_cap: assert property (p_safe0v_cap) else $error("detach wait overran");

  property p_pg_prot;
    @(posedge pclk) disable iff (!presetn) (dovp_pg || ovuv_s || otp_s) |=> !power_good_out;
  endproperty
  a_pg_prot: assert property (p_pg_prot) else $error("power-good high under fault");
endmodule : ups_sequencer
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: Self-checking bench for the port protection sequencer.
// Assumes: Shortened delay parameters; sink model on the CC side.
// Notes: Delays are checked as cycle windows around the counts set here.
`default_nettype none
module tb_top
  import ups_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DSW = 20, DPG = 10, RS = 30, RL = 60, S0V = 40;
  localparam int O_CEN = 0, O_SSPD = 1, O_VDIS = 2, O_DSW = 3, O_PG = 4, O_GATE = 5;
  localparam int O_PU1 = 6, O_PU2 = 7;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rng;
  logic [13:0] fl;
  logic cen, sspd, vdis, dsw, pg, gate, pu1, pu2, plug, flip, stall, rd1, rd2, s0v;
  logic [7:0] outs;
  logic [3:0] ss_sh;
  logic [1:0] cur;
  logic [1:0] seq [6];
  int f [4];
  int num_errors, n_checks, n, n1, j;
  assign outs = {pu2, pu1, gate, pg, dsw, vdis, sspd, cen};

  // ---------------------------------------------------------------
  // Clock, converter stand-in, instances
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Soft-start finishes a few cycles after the converter runs
  always @(posedge pclk) ss_sh <= {ss_sh[2:0], cen};
  ups_sequencer #(.DSW_ON_CYCLES(DSW), .DOVP_PG_CYCLES(DPG), .RST_SHORT_CYCLES(RS),
    .RST_LONG_CYCLES(RL), .SAFE0V_CYCLES(S0V)) uut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .over_temp(fl[I_OTP]), .host_data_pos_ovp(fl[I_DP]), .host_data_neg_ovp(fl[I_DN]),
    .cc1_ovp(fl[I_CC1OV]), .cc2_ovp(fl[I_CC2OV]), .cc1_rd_seen(rd1), .cc2_rd_seen(rd2),
    .vbus_safe0v(s0v), .feedback_node_low(fl[I_FBLOW]), .overvoltage_trip(fl[I_OVP]),
    .undervoltage_trip(fl[I_UVP]), .vcc_por_ok(fl[I_POR]), .soft_start_done(&ss_sh),
    .reset_timeout(fl[I_TMO]), .converter_enable(cen), .soft_start_pulldown(sspd),
    .vbus_discharge(vdis), .data_switch_on(dsw), .power_good_out(pg),
    .blocking_gate_on(gate), .cc1_pullup_on(pu1), .cc2_pullup_on(pu2));
  ups_sink_model sink (.pclk(pclk), .presetn(presetn), .plug(plug), .flip(flip),
    .stall(stall), .blocking_gate_on(gate), .vbus_discharge(vdis), .cc1_rd_seen(rd1),
    .cc2_rd_seen(rd2), .vbus_safe0v(s0v));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic int rst_len(input logic [1:0] o, input logic [1:0] m);
    return (o == MODE_DCP && m != MODE_DCP) ? RS : RL;
  endfunction : rst_len
  task conclude;
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chk_rng(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : chk_rng
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      num_errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask : apb
  task wmode(input logic [1:0] m, input logic en);
    rng = xs(rng);
    apb(1'b1, CTRL_OFS, {rng[31:3], m, en});
  endtask : wmode
  task setf(input int i, input logic v);
    @(posedge pclk);
    fl[i] <= v;
    @(negedge pclk);
  endtask : setf
  // Bounded wait for an output level, counted in cycles
  task wait_o(input int i, input logic v, input int maxc);
    for (n = 0; n < maxc; n++) begin
      if (outs[i] === v) break;
      @(negedge pclk);
    end
    if (outs[i] !== v) begin
      num_errors++;
      conclude();
    end
  endtask : wait_o

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    conclude();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, fl, plug, flip, stall, ss_sh} = '0;
    presetn = 1'b0;
    rng = 32'd56751;
    seq = '{MODE_CDP, MODE_DCP, MODE_SDP, MODE_DCP, MODE_CDP, MODE_SDP};
    f = '{I_OTP, I_OVP, I_UVP, I_FBLOW};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({24'h0, outs}, 32'h0000_00C0);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, MODE_RST, CTRL_EN_RST});
    apb(1'b1, CTRL_OFS, 32'h0000_0006);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk({29'h0, rd[2:0]}, {29'h0, MODE_RST, 1'b0});
    for (j = 0; j < 4; j++) begin
      rng = xs(rng);
      apb(1'b0, 12'h008 + {2'h0, rng[9:2], 2'h0}, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
    end
    apb(1'b1, STAT_OFS, rng);
    chk({31'h0, err}, 32'h1);
    wmode(MODE_SDP, 1'b0);
    setf(I_POR, 1'b1);
    wait_o(O_DSW, 1'b1, DSW + 10);
    chk_rng(n, DSW - 1, DSW + 6);
    wmode(MODE_SDP, 1'b1);
    wait_o(O_PG, 1'b1, 2 * RL + 100);
    chk({31'h0, dsw}, 32'h1);
    cur = MODE_SDP;
    for (j = 0; j < 6; j++) begin
      wmode(seq[j], 1'b1);
      wait_o(O_SSPD, 1'b1, 10);
      n1 = n;
      repeat (3) @(negedge pclk);
      chk({30'h0, cen, vdis}, 32'h1);
      wait_o(O_SSPD, 1'b0, RL + 20);
      chk_rng(n + 3, rst_len(cur, seq[j]) - 3, rst_len(cur, seq[j]) + 3);
      wait_o(O_CEN, 1'b1, 20);
      wait_o(O_PG, 1'b1, 60);
      if (seq[j] != MODE_DCP) chk({31'h0, dsw}, 32'h1);
      cur = seq[j];
    end
    wmode(MODE_CDP, 1'b1);
    wait_o(O_SSPD, 1'b1, 10);
    repeat (20) @(negedge pclk);
    setf(I_TMO, 1'b1);
    setf(I_TMO, 1'b0);
    wait_o(O_SSPD, 1'b0, RL + 40);
    chk_rng(n, RL - 4, RL + 8);
    wait_o(O_PG, 1'b1, 60);
    for (j = 0; j < 4; j++) begin
      setf(f[j], 1'b1);
      repeat (6) @(negedge pclk);
      chk({31'h0, pg}, 32'h0);
      if (j == 0) chk({31'h0, cen}, 32'h0);
      setf(f[j], 1'b0);
      wait_o(O_SSPD, 1'b1, 20);
      wait_o(O_SSPD, 1'b0, RL + 20);
      wait_o(O_PG, 1'b1, 2 * RL + 60);
    end
    setf(I_DP, 1'b1);
    wait_o(O_PG, 1'b0, DPG + 10);
    chk_rng(n, DPG - 1, DPG + 5);
    n1 = n;
    wait_o(O_DSW, 1'b0, 300);
    chk_rng(n + n1, DOVP_SW_CYC - 2, DOVP_SW_CYC + 6);
    setf(I_DN, 1'b1);
    setf(I_DP, 1'b0);
    repeat (DPG + 10) @(negedge pclk);
    chk({30'h0, pg, dsw}, 32'h0);
    setf(I_DN, 1'b0);
    wait_o(O_PG, 1'b1, DPG + 10);
    wait_o(O_SSPD, 1'b1, 10);
    wait_o(O_SSPD, 1'b0, RS + 20);
    chk_rng(n, RS - 5, RS + 3);
    wait_o(O_DSW, 1'b1, 300);
    wait_o(O_PG, 1'b1, RS + 60);
    flip <= 1'b1;
    plug <= 1'b1;
    wait_o(O_GATE, 1'b1, 10);
    repeat (12) @(negedge pclk);
    stall <= 1'b1;
    plug <= 1'b0;
    wait_o(O_PU2, 1'b0, 10);
    chk({30'h0, pu1, vdis}, 32'h3);
    repeat (S0V - 12) @(negedge pclk);
    chk({31'h0, pu2}, 32'h0);
    wait_o(O_PU2, 1'b1, 20);
    stall <= 1'b0;
    flip <= 1'b0;
    plug <= 1'b1;
    wait_o(O_GATE, 1'b1, 10);
    repeat (12) @(negedge pclk);
    plug <= 1'b0;
    wait_o(O_PU1, 1'b0, 10);
    wait_o(O_PU1, 1'b1, S0V - 15);
    plug <= 1'b1;
    wait_o(O_GATE, 1'b1, 10);
    rng = xs(rng);
    setf(I_CC1OV + rng[0], 1'b1);
    wait_o(O_GATE, 1'b0, 6);
    chk({31'h0, pg}, 32'h0);
    wait_o(O_VDIS, 1'b1, 6);
    setf(I_CC1OV + rng[0], 1'b0);
    wait_o(O_PG, 1'b1, 2 * RL + 80);
    wait_o(O_GATE, 1'b1, 20);
    wmode(MODE_CDP, 1'b0);
    setf(I_POR, 1'b0);
    wait_o(O_DSW, 1'b0, 6);
    conclude();
  end
endmodule : tb_top
`default_nettype wire

// File: tb/ups_sink_model.sv
// Purpose: Behavioural sink device attached at the Type-C port.
// Assumes: VBUS is tracked as a small level count that the gate raises.
// Notes: stall holds VBUS up after detach, so the forced pull-up path runs.
`default_nettype none
module ups_sink_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Scenario control
  input wire logic plug,
  input wire logic flip,
  input wire logic stall,
  // From the port
  input wire logic blocking_gate_on,
  input wire logic vbus_discharge,
  // To the port
  output logic cc1_rd_seen,
  output logic cc2_rd_seen,
  output logic vbus_safe0v
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] vbus_lvl_reg;
  // Rd shows on one CC only, chosen by cable orientation
  assign cc1_rd_seen = plug & ~flip;
  assign cc2_rd_seen = plug & flip;
  assign vbus_safe0v = (vbus_lvl_reg == 4'h0);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vbus_lvl_reg <= 4'h0;
    end else if (blocking_gate_on && vbus_lvl_reg != 4'h8) begin
      vbus_lvl_reg <= vbus_lvl_reg + 4'h1;
    end else if (!blocking_gate_on && vbus_discharge && !stall && vbus_lvl_reg != 4'h0) begin
      vbus_lvl_reg <= vbus_lvl_reg - 4'h1;
    end
  end
endmodule : ups_sink_model
`default_nettype wire
